// ---- afe_consts.svh ----
// Constants for the scanner front end serial control and output logic.
// Included by the design modules, not by afe_pkg.sv; definitions only.
`ifndef AFE_CONSTS_SVH
`define AFE_CONSTS_SVH

// ----------------------------------------
// Register addresses (six bit)
// ----------------------------------------
`define ADDR_SETUP1 6'h01
`define ADDR_SETUP2 6'h02
`define ADDR_SETUP3 6'h03
`define ADDR_SOFT_RESET 6'h04
`define ADDR_SETUP4 6'h06
`define ADDR_REVISION 6'h07
`define ADDR_SETUP5 6'h08
`define ADDR_TEST1 6'h09
`define ADDR_READ_BIT 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DEF_SETUP1 8'h0f
`define DEF_SETUP2 8'h23
`define DEF_SETUP3 8'h1f
`define DEF_SETUP4 8'h05
`define DEF_SETUP5 8'h00
`define DEF_TEST1 8'h00
`define REVISION_CODE 8'h41

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_POWER_EN 0
`define BIT_MAX_SPEED 6
`define FS_HI 5
`define FS_LO 4
`define BIT_INVERT 2
`define LAT_HI 7
`define LAT_LO 6
`define BIT_EDGE_EN 0
`define DLY_HI 3
`define DLY_LO 1
`define BIT_EDGE_POL 4

// ----------------------------------------
// Code arithmetic
// ----------------------------------------
`define CODE_MID 18'sh07fff
`define CODE_FULL 18'sh0ffff
`define FRAME_BITS 14
`define LAT_BASE 2

`endif

// ---- afe_pkg.sv ----
// Types shared by the front end control logic.
// Assumes afe_consts.svh is on the include path.
package afe_pkg;
    typedef enum logic [1:0] {
        FS_MID_A,
        FS_MID_B,
        FS_TOP,
        FS_BOTTOM
    } full_scale_e;
    typedef logic [7:0] reg_byte_t;
endpackage

// ---- afe_serial_link.sv ----
// Serial shift logic on the shift clock domain.
// Assumes the load strobe is synchronised by the parent; the read-request toggle is synchronised here.
`timescale 1ns/10ps
`include "afe_consts.svh"
module afe_serial_link
    import afe_pkg::*;
(
    input wire logic shift_clk, // Serial shift clock
    input wire logic nrst, // Async reset, active low
    input wire logic serial_data_in, // Serial data in
    input wire logic load_toggle, // Toggle from core: reload read word
    input wire reg_byte_t read_word, // Word to send, stable when toggled
    output logic [13:0] frame, // Last fourteen bits shifted in
    output logic serial_data_out, // Read-back bit
    output logic sending // Read-back in progress
);
    logic [13:0] next_frame;
    logic [7:0] out_shift;
    logic [7:0] next_out_shift;
    logic [3:0] out_count;
    logic [3:0] next_out_count;
    logic tog_s1, tog_s2, tog_seen;
    logic next_out;
    logic out_q;

    // ----------------------------------------
    // Input shift, rising edge
    // ----------------------------------------
    always_comb begin
        next_frame = {frame[12:0], serial_data_in}; // [R1] [R2]
    end

    always_ff @(posedge shift_clk or negedge nrst) begin
        if (!nrst) begin
            frame <= 14'h0000;
        end else begin
            frame <= next_frame; // [R2]
        end
    end

    // ----------------------------------------
    // Output shift, falling edge
    // ----------------------------------------
    always_comb begin
        next_out_shift = out_shift;
        next_out_count = out_count;
        next_out = out_q;
        if (tog_s2 != tog_seen) begin
            next_out_shift = {read_word[6:0], 1'b0};
            next_out_count = 4'h8; // Bits still to stand on the pin, last one included
            next_out = read_word[7]; // [R7]
        end else if (out_count > 4'h1) begin
            next_out = out_shift[7]; // [R7]
            next_out_shift = {out_shift[6:0], 1'b0};
            next_out_count = out_count - 4'h1;
        end else begin
            next_out = 1'b0;
            next_out_count = 4'h0;
        end
    end

    always_ff @(negedge shift_clk or negedge nrst) begin
        if (!nrst) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_seen <= 1'b0;
            out_shift <= 8'h00;
            out_count <= 4'h0;
            out_q <= 1'b0;
        end else begin
            tog_s1 <= load_toggle;
            tog_s2 <= tog_s1;
            tog_seen <= tog_s2;
            out_shift <= next_out_shift;
            out_count <= next_out_count;
            out_q <= next_out;
        end
    end

    assign serial_data_out = out_q;
    assign sending = (out_count != 4'h0) || (tog_s2 != tog_seen);
endmodule

// ---- afe_serial_control_output.sv ----
// Serial control registers, output code and nibble output of the front end.
// Assumes sys_clk is the master clock and shift_clk the controller's shift clock.
//
// Overview of operation
// R1: Six address bits then eight data bits
// R2: Input bits captured on shift rising edge
// R3: Load strobe moves byte into register
// R4: Address bit a4 clear means write
// R5: Address 000100 restores all defaults
// R6: a4 set reads register with a4 cleared
// R7: Read-back MSB first on falling edges
// R8: Read-back shares top nibble output pin
// R9: Next word may enter during read-back
// R10: Nibbles go from bits 15 to 0
// R11: Two-bit field selects output latency
// R12: Full-scale field sets offset, then clip
// R13: Invert bit outputs 65535 minus code
// R14: Sample taken after pulse goes low
// R15: Edge detect on chosen sample pulse edge
// R16: Detected pulse delayed by three-bit field
// R17: Power-down keeps registers, serial port alive
// R18: Controller keeps mode clock ratios
// R19: Controller programs setup register for mode
// R20: Clock limits 24 and 12 MHz
// R21: Software reset advised after power-up
// R22: Power enable bit 0, default one
// R23: Invert bit 2 of second setup register
// R24: Nibbles in strict consecutive slot order
// R25: Writes to undefined addresses ignored
`timescale 1ns/10ps
`include "afe_consts.svh"
module afe_serial_control_output
    import afe_pkg::*;
(
    input wire logic sys_clk, // Master clock
    input wire logic nrst, // Async reset, active low
    input wire logic shift_clk, // Serial shift clock
    input wire logic serial_data_in, // Serial data in
    input wire logic serial_load_strobe, // Load strobe pin
    input wire logic pixel_sample_pulse, // Sample pulse pin
    input wire logic signed [17:0] raw_code, // Converter result before offset
    output logic [3:0] nibble_output_bus, // Nibble bus, bit 3 shared
    output logic sample_taken, // One-cycle sample instant
    output logic powered_up // Power enable state
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg_byte_t setup1, setup2, setup3, setup4, setup5, test1;
    reg_byte_t next_setup1, next_setup2, next_setup3, next_setup4, next_setup5, next_test1;
    reg_byte_t read_word, next_read_word;
    logic load_toggle, next_load_toggle;
    logic [13:0] frame;
    logic link_sdo, link_sending;
    logic [13:0] frame_s1, frame_s2;
    logic sdo_s1, sdo_s2, send_s1, send_s2;
    logic strobe_s1, strobe_s2, strobe_d;
    logic pin_s1, pin_s2, pin_d;
    logic [7:0] dly_pipe, next_dly_pipe;
    logic pulse_d, next_pulse_d;
    logic sample_q, next_sample_q;
    logic [15:0] code, next_code;
    logic [3:0] lat_pipe, next_lat_pipe;
    logic [1:0] slot, next_slot;
    logic sending_nib, next_sending_nib;
    logic [3:0] nib_q, next_nib_q;
    logic [5:0] addr;
    reg_byte_t data;
    logic load_edge;
    logic internal_pulse;
    logic [2:0] vdel;
    logic signed [18:0] offset_code; // One bit of headroom so the sum cannot wrap
    logic [15:0] clipped;
    logic [1:0] latency;

    assign addr = frame_s2[13:8];
    assign data = frame_s2[7:0];
    assign load_edge = strobe_s2 && !strobe_d;
    assign vdel = setup5[`DLY_HI:`DLY_LO];
    assign latency = setup2[`LAT_HI:`LAT_LO];

    // ----------------------------------------
    // Serial link on the shift clock
    // ----------------------------------------
    afe_serial_link link_u (
        .shift_clk(shift_clk),
        .nrst(nrst),
        .serial_data_in(serial_data_in),
        .load_toggle(load_toggle),
        .read_word(read_word),
        .frame(frame),
        .serial_data_out(link_sdo),
        .sending(link_sending)
    );

    // ----------------------------------------
    // Synchronisers into the master clock domain
    // ----------------------------------------
    // Frame is stable while the strobe pulse is high, so a plain
    // two-stage capture is safe to read at the strobe edge.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            frame_s1 <= 14'h0000;
            frame_s2 <= 14'h0000;
            strobe_s1 <= 1'b0;
            strobe_s2 <= 1'b0;
            strobe_d <= 1'b0;
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_d <= 1'b0;
            sdo_s1 <= 1'b0;
            sdo_s2 <= 1'b0;
            send_s1 <= 1'b0;
            send_s2 <= 1'b0;
        end else begin
            frame_s1 <= frame;
            frame_s2 <= frame_s1;
            strobe_s1 <= serial_load_strobe;
            strobe_s2 <= strobe_s1;
            strobe_d <= strobe_s2;
            pin_s1 <= pixel_sample_pulse;
            pin_s2 <= pin_s1;
            pin_d <= pin_s2;
            sdo_s1 <= link_sdo;
            sdo_s2 <= sdo_s1;
            send_s1 <= link_sending;
            send_s2 <= send_s1;
        end
    end

    // ----------------------------------------
    // Register file and read request
    // ----------------------------------------
    always_comb begin
        next_setup1 = setup1;
        next_setup2 = setup2;
        next_setup3 = setup3;
        next_setup4 = setup4;
        next_setup5 = setup5;
        next_test1 = test1;
        next_read_word = read_word;
        next_load_toggle = load_toggle;
        if (load_edge) begin // [R3]
            if (addr[`ADDR_READ_BIT]) begin // [R6]
                // Read of register with a4 cleared
                if ({addr[5], 1'b0, addr[3:0]} == `ADDR_SETUP1) begin
                    next_read_word = setup1;
                end else if ({addr[5], 1'b0, addr[3:0]} == `ADDR_SETUP2) begin
                    next_read_word = setup2;
                end else if ({addr[5], 1'b0, addr[3:0]} == `ADDR_SETUP3) begin
                    next_read_word = setup3;
                end else if ({addr[5], 1'b0, addr[3:0]} == `ADDR_SETUP4) begin
                    next_read_word = setup4;
                end else if ({addr[5], 1'b0, addr[3:0]} == `ADDR_REVISION) begin
                    next_read_word = `REVISION_CODE;
                end else if ({addr[5], 1'b0, addr[3:0]} == `ADDR_SETUP5) begin
                    next_read_word = setup5;
                end else if ({addr[5], 1'b0, addr[3:0]} == `ADDR_TEST1) begin
                    next_read_word = test1;
                end else begin
                    next_read_word = 8'h00;
                end
                next_load_toggle = !load_toggle; // [R9]
            end else if (addr == `ADDR_SETUP1) begin // [R4]
                next_setup1 = data;
            end else if (addr == `ADDR_SETUP2) begin
                next_setup2 = data;
            end else if (addr == `ADDR_SETUP3) begin
                next_setup3 = data;
            end else if (addr == `ADDR_SETUP4) begin
                next_setup4 = data;
            end else if (addr == `ADDR_SETUP5) begin
                next_setup5 = data;
            end else if (addr == `ADDR_TEST1) begin
                next_test1 = data;
            end else if (addr == `ADDR_SOFT_RESET) begin // [R5]
                next_setup1 = `DEF_SETUP1;
                next_setup2 = `DEF_SETUP2;
                next_setup3 = `DEF_SETUP3;
                next_setup4 = `DEF_SETUP4;
                next_setup5 = `DEF_SETUP5;
                next_test1 = `DEF_TEST1;
            end
            // Other addresses leave every register alone [R25]
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            setup1 <= `DEF_SETUP1; // [R22]
            setup2 <= `DEF_SETUP2; // [R23]
            setup3 <= `DEF_SETUP3;
            setup4 <= `DEF_SETUP4;
            setup5 <= `DEF_SETUP5;
            test1 <= `DEF_TEST1;
            read_word <= 8'h00;
            load_toggle <= 1'b0;
        end else begin
            setup1 <= next_setup1;
            setup2 <= next_setup2;
            setup3 <= next_setup3;
            setup4 <= next_setup4;
            setup5 <= next_setup5;
            test1 <= next_test1;
            read_word <= next_read_word;
            load_toggle <= next_load_toggle;
        end
    end

    // ----------------------------------------
    // Sample pulse and edge detector
    // ----------------------------------------
    // Detected edge enters a shift pipe; delay field picks the tap
    always_comb begin
        next_dly_pipe = {dly_pipe[6:0], setup5[`BIT_EDGE_POL] ? (pin_s2 && !pin_d) : (!pin_s2 && pin_d)}; // [R15]
        internal_pulse = setup5[`BIT_EDGE_EN] ? dly_pipe[vdel] : pin_s2; // [R16]
        next_pulse_d = internal_pulse;
        // Sample on first edge after the pulse goes low [R14]
        next_sample_q = pulse_d && !internal_pulse && setup1[`BIT_POWER_EN]; // [R17]
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dly_pipe <= 8'h00;
            pulse_d <= 1'b0;
            sample_q <= 1'b0;
        end else begin
            dly_pipe <= next_dly_pipe;
            pulse_d <= next_pulse_d;
            sample_q <= next_sample_q;
        end
    end

    // ----------------------------------------
    // Output code: offset, clip, invert
    // ----------------------------------------
    always_comb begin
        case (full_scale_e'(setup1[`FS_HI:`FS_LO]))
            FS_MID_A: offset_code = raw_code + `CODE_MID; // [R12]
            FS_MID_B: offset_code = raw_code + `CODE_MID;
            FS_TOP: offset_code = raw_code + `CODE_FULL;
            default: offset_code = raw_code;
        endcase
        if (offset_code < 18'sh00000) begin
            clipped = 16'h0000;
        end else if (offset_code > `CODE_FULL) begin
            clipped = 16'hffff;
        end else begin
            clipped = offset_code[15:0];
        end
        // 65535 minus code equals bitwise complement [R13]
        next_code = setup2[`BIT_INVERT] ? ~clipped : clipped;
        if (!sample_q) begin
            next_code = code;
        end
    end

    // ----------------------------------------
    // Latency and nibble sequencing
    // ----------------------------------------
    always_comb begin
        next_lat_pipe = {lat_pipe[2:0], sample_q};
        next_slot = slot;
        next_sending_nib = sending_nib;
        if (lat_pipe[latency]) begin // [R11]
            next_slot = 2'h0;
            next_sending_nib = 1'b1;
        end else if (sending_nib) begin
            next_slot = slot + 2'h1; // [R24]
            next_sending_nib = (slot != 2'h3);
        end
        case (next_slot)
            2'h0: next_nib_q = code[15:12]; // [R10]
            2'h1: next_nib_q = code[11:8];
            2'h2: next_nib_q = code[7:4];
            default: next_nib_q = code[3:0];
        endcase
        if (!setup1[`BIT_POWER_EN]) begin
            next_nib_q = 4'h0;
        end
        if (send_s2) begin
            next_nib_q[3] = sdo_s2; // [R8]
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            code <= 16'h0000;
            lat_pipe <= 4'h0;
            slot <= 2'h0;
            sending_nib <= 1'b0;
            nib_q <= 4'h0;
        end else begin
            code <= next_code;
            lat_pipe <= next_lat_pipe;
            slot <= next_slot;
            sending_nib <= next_sending_nib;
            nib_q <= next_nib_q;
        end
    end

    assign nibble_output_bus = nib_q;
    assign sample_taken = sample_q;
    assign powered_up = setup1[`BIT_POWER_EN];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_soft_reset_defaults: assert property (@(posedge sys_clk) disable iff (!nrst) // [R5]
        load_edge && addr == `ADDR_SOFT_RESET |=> setup1 == `DEF_SETUP1 && setup2 == `DEF_SETUP2)
        else $error("soft reset did not restore defaults");
    a_read_no_write: assert property (@(posedge sys_clk) disable iff (!nrst) // [R4]
        load_edge && addr[`ADDR_READ_BIT] |=> $stable(setup1) && $stable(setup5))
        else $error("read request changed a register");
    a_undef_ignored: assert property (@(posedge sys_clk) disable iff (!nrst) // [R25]
        load_edge && addr == 6'h05 |=> $stable(setup2) && $stable(test1))
        else $error("undefined address changed a register");
    a_write_setup2: assert property (@(posedge sys_clk) disable iff (!nrst) // [R3]
        load_edge && addr == `ADDR_SETUP2 |=> setup2 == $past(data))
        else $error("write did not land");
    a_power_no_sample: assert property (@(posedge sys_clk) disable iff (!nrst) // [R17]
        !setup1[`BIT_POWER_EN] |=> !sample_q)
        else $error("sample while powered down");
    a_sample_after_fall: assert property (@(posedge sys_clk) disable iff (!nrst) // [R14]
        setup1[`BIT_POWER_EN] && $fell(internal_pulse) |=> sample_q)
        else $error("sample not after pulse fell");
    a_invert_code: assert property (@(posedge sys_clk) disable iff (!nrst) // [R13]
        sample_q && setup2[`BIT_INVERT] |=> code == ~$past(clipped))
        else $error("inverted code wrong");
    a_nibble_order: assert property (@(posedge sys_clk) disable iff (!nrst) // [R24]
        sending_nib && slot == 2'h0 && !lat_pipe[latency] |=> slot == 2'h1 ##1 slot == 2'h2)
        else $error("nibble slots out of order");
    a_read_toggles: assert property (@(posedge sys_clk) disable iff (!nrst) // [R6]
        load_edge && addr[`ADDR_READ_BIT] |=> load_toggle != $past(load_toggle))
        else $error("read request not passed on");
endmodule

// ---- afe_controller_model.sv ----
// Scanner controller model: drives the serial register port of the front end.
// Assumes sys_clk is the master clock; readback_bit is nibble bus bit 3.
`timescale 1ns/10ps
module afe_controller_model (
    input wire logic sys_clk, // Master clock
    input wire logic readback_bit, // Shared nibble bus bit 3
    output logic shift_clk, // Serial shift clock
    output logic serial_data_in, // Serial data to device
    output logic serial_load_strobe // Load strobe
);
    // ----------------------------------------
    // Idle levels
    // ----------------------------------------
    initial begin
        shift_clk = 1'b0;
        serial_data_in = 1'b0;
        serial_load_strobe = 1'b0;
    end

    // ----------------------------------------
    // One frame, then strobe, then read-back clocking
    // ----------------------------------------
    // Shift clock stands low outside frames; read-back bits are held long enough for sys_clk
    task automatic transfer(input logic [5:0] addr, input logic [7:0] data, output logic [7:0] rd);
        logic [13:0] word;
        word = {addr, data}; // Address then data, MSB first
        rd = 8'h00;
        for (int i = 13; i >= 0; i--) begin
            serial_data_in = word[i];
            #16 shift_clk = 1'b1;
            #16 shift_clk = 1'b0;
        end
        serial_data_in = ~word[0]; // Released line shows no stale bit
        @(posedge sys_clk);
        serial_load_strobe <= 1'b1; // Load after all bits are
        repeat (3) @(posedge sys_clk);
        serial_load_strobe <= 1'b0;
        repeat (5) @(posedge sys_clk);
        if (addr[4]) begin // Read request with dummy byte
            for (int k = 1; k <= 11; k++) begin
                serial_data_in = ~serial_data_in; // Next word may shift in meanwhile
                #16 shift_clk = 1'b1;
                #16 shift_clk = 1'b0;
                #600;
                if (k >= 3 && k <= 10) begin
                    rd = {rd[6:0], readback_bit};
                end
            end
        end
    endtask
endmodule

// ---- afe_serial_control_output_tb_top.sv ----
// Self-checking bench for the front end serial control and output logic.
// Assumes afe_pkg, afe_consts.svh and the controller model are compiled first.
`timescale 1ns/10ps
module afe_serial_control_output_tb_top;
    import afe_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst;
    logic shift_clk;
    logic serial_data_in;
    logic serial_load_strobe;
    logic pixel_sample_pulse = 1'b0;
    logic signed [17:0] raw_code = 18'sh00000;
    logic [3:0] nibble_output_bus;
    logic sample_taken;
    logic powered_up;
    logic [31:0] seed = 32'h00004ce0; // Fixed start 19680
    logic [31:0] r32;
    logic [7:0] got;
    logic [7:0] wdat;
    logic [15:0] code;
    logic [1:0] lat;
    int t;
    int t0;
    int fails = 0;
    int tests_run = 0;
    logic [5:0] def_addr [7] = '{6'h01, 6'h02, 6'h03, 6'h06, 6'h07, 6'h08, 6'h09};
    logic [7:0] def_val [7] = '{8'h0f, 8'h23, 8'h1f, 8'h05, 8'h41, 8'h00, 8'h00};

    // ----------------------------------------
    // Clock, design and controller
    // ----------------------------------------
    // Master clock 10 MHz, under the 24 MHz limit
    always #50 sys_clk = ~sys_clk;

    afe_serial_control_output DUT (.sys_clk(sys_clk), .nrst(nrst), .shift_clk(shift_clk),
        .serial_data_in(serial_data_in), .serial_load_strobe(serial_load_strobe),
        .pixel_sample_pulse(pixel_sample_pulse), .raw_code(raw_code),
        .nibble_output_bus(nibble_output_bus), .sample_taken(sample_taken), .powered_up(powered_up));

    afe_controller_model ctrl (.sys_clk(sys_clk), .readback_bit(nibble_output_bus[3]), .shift_clk(shift_clk),
        .serial_data_in(serial_data_in), .serial_load_strobe(serial_load_strobe));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Xorshift generator
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected output code: offset, clip, invert
    function automatic logic [15:0] exp_code(input logic signed [17:0] raw, input logic [1:0] fs, input logic inv);
        int v;
        v = raw + ((fs == 2'b10) ? 65535 : (fs == 2'b11) ? 0 : 32767);
        v = (v < 0) ? 0 : (v > 65535) ? 65535 : v;
        v = inv ? 65535 - v : v;
        return v[15:0];
    endfunction

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_nibble(input string what, input logic [3:0] exp, input logic [3:0] seen);
        check_byte(what, {4'h0, exp}, {4'h0, seen});
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] unused;
        ctrl.transfer(a, d, unused);
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        r32 = rnd();
        ctrl.transfer({a[5], 1'b1, a[3:0]}, r32[7:0], d);
    endtask

    // Pulse the pin for hi cycles; tc counts edges from the rise until sample_taken, 40 if none
    task automatic sample(input int hi, output int tc);
        int n;
        tc = 40;
        n = 0;
        @(posedge sys_clk);
        pixel_sample_pulse <= 1'b1;
        // Pin always returns low, so pulses stay spaced by the mode ratio
        while (n < 40 && (tc == 40 || n < hi)) begin
            @(posedge sys_clk);
            n++;
            if (n == hi) pixel_sample_pulse <= 1'b0;
            #1;
            if (tc == 40 && sample_taken === 1'b1) tc = n;
        end
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial begin
        #3000000;
        fails++;
        final_report();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        nrst <= 1'b0; // Falling edge at time zero resets both domains
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        #1;
        check_byte("powered_up after reset", 8'h01, {7'h00, powered_up});
        r32 = rnd();
        wr(6'h04, r32[7:0]); // Software reset first
        // Defaults read back MSB first on the shared pin
        for (int i = 0; i < 7; i++) begin
            rd(def_addr[i], got);
            check_byte("default", def_val[i], got);
        end
        // Random write, undefined address, software reset
        r32 = rnd();
        wdat = r32[7:0];
        wr(6'h03, wdat);
        rd(6'h03, got);
        check_byte("setup3 written", wdat, got);
        wr(6'h05, ~wdat);
        rd(6'h05, got);
        check_byte("undefined address", 8'h00, got);
        rd(6'h03, got);
        check_byte("setup3 kept", wdat, got);
        wr(6'h04, wdat);
        rd(6'h03, got);
        check_byte("setup3 after soft reset", 8'h1f, got);
        // Output code for every full-scale and invert setting
        for (int fs = 0; fs < 4; fs++) begin
            for (int inv = 0; inv < 2; inv++) begin
                lat = 2'(fs * 2 + inv);
                wr(6'h01, {2'b00, 2'(fs), 4'hf}); // Standard mode setup
                wr(6'h02, {lat, 3'b000, 1'(inv), 2'b11});
                for (int n = 0; n < 3; n++) begin
                    r32 = rnd();
                    raw_code <= (n == 0) ? 18'sh00000 : r32[17:0];
                    sample(1, t);
                    check_byte("sample delay", 8'd4, 8'(t));
                    code = exp_code(raw_code, 2'(fs), 1'(inv));
                    repeat (int'(lat) + 2) @(posedge sys_clk); // First nibble latency plus two after sample
                    #1;
                    for (int s = 0; s < 4; s++) begin
                        check_nibble("nibble", code[15 - 4 * s -: 4], 4'h0 | nibble_output_bus);
                        @(posedge sys_clk);
                        #1;
                    end
                end
            end
        end
        // Edge detection: polarity and delay relative to a measured base
        wr(6'h08, 8'h11);
        sample(10, t0);
        r32 = rnd();
        wr(6'h08, {4'b0001, r32[2:0], 1'b1});
        sample(10, t);
        check_byte("detect delay", 8'(t0 + int'(r32[2:0])), 8'(t));
        wr(6'h08, 8'h01);
        sample(10, t);
        check_byte("falling edge detect", 8'(t0 + 10), 8'(t));
        wr(6'h08, 8'h00);
        // Power-down keeps registers and the serial port
        wr(6'h01, 8'h0e);
        check_byte("powered_up off", 8'h00, {7'h00, powered_up});
        sample(1, t);
        check_byte("no sample powered down", 8'd40, 8'(t));
        check_nibble("bus powered down", 4'h0, nibble_output_bus);
        rd(6'h02, got);
        check_byte("setup2 kept", {lat, 6'b000111}, got);
        wr(6'h01, 8'h0f);
        check_byte("powered_up on", 8'h01, {7'h00, powered_up});
        final_report();
    end
endmodule
